// ===== verification/dsac_link_props.sv
`default_nettype none
module dsac_link_props (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // offsets with no register behind them
   wire unmapped = (reg_addr < 8'h04) || (reg_addr > 8'h09);
   property p_ack_pulse; reg_ack |=> !reg_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_ack_cause; reg_ack |-> reg_req && $past(reg_req); endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   property p_answer; $rose(reg_req) |=> reg_ack; endproperty
   a_answer: assert property (p_answer)
      else $error("answer not one cycle after request");
   // qualifiers frozen while the request waits
   property p_req_hold;
      reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
         && $stable(reg_we) && $stable(reg_wdata);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request changed before ack");
   property p_drop; reg_ack |=> !reg_req; endproperty
   a_drop: assert property (p_drop)
      else $error("request kept after ack");
   property p_unmapped; reg_ack && unmapped |-> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped offset read nonzero");
   property p_ckdiv_top;
      reg_ack && reg_addr == 8'h09 |-> reg_rdata[7:5] == 3'h0;
   endproperty
   a_ckdiv_top: assert property (p_ckdiv_top)
      else $error("divider upper bits nonzero");
   property p_filt_lsb; reg_ack && reg_addr == 8'h08 |-> !reg_rdata[0];
   endproperty
   a_filt_lsb: assert property (p_filt_lsb)
      else $error("filter control bit 0 nonzero");
   // main traffic kinds
   c_write: cover property (reg_ack && reg_we);
   c_read_hi: cover property (reg_ack && reg_addr == 8'h06);
   c_unmapped: cover property (reg_ack && unmapped);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic signed [25:0] sample_data = 26'h0;
   dsac_pkg::dsac_mode_e op_mode;
   logic mod_on, filt_on, filt_rst, ref_ext, neg_on, pos_on, tick, done;
   int n_mismatch = 0;
   int tests_run = 0;
   int n;
   dsac_if link ();
   dsac_dev dsac_dev_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(link),
      .sample_data(sample_data), .op_mode(op_mode), .modulator_on(mod_on),
      .filter_on(filt_on), .filter_reset(filt_rst), .ref_ext_sel(ref_ext),
      .neg_ref_buffer_on(neg_on), .pos_ref_buffer_on(pos_on),
      .adck_tick(tick), .conv_done(done));
   dsac_host dsac_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   dsac_link_props dsac_link_props_i (.clk_sys(clk_sys), .rst_b(rst_b),
      .reg_req(link.reg_req), .reg_we(link.reg_we),
      .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
      .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack));
   initial forever #2.5 clk_sys = ~clk_sys;
   task check(input logic [31:0] seen, input logic [31:0] exp,
      input string name);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // host command, then poll busy until it clears, with no bound
   task cmd(input logic [2:0] op, input logic [7:0] off, input logic [7:0] by);
      apb(1'b1, 8'h00, {13'h0, op, by, off});
      do begin
         apb(1'b0, 8'h04, 32'h0);
      end while (rd[0] !== 1'b0);
   endtask
   task dev_rd(input logic [7:0] off, input logic [7:0] exp, input string s);
      cmd(3'h0, off, 8'h00);
      check({24'h0, rd[15:8]}, {24'h0, exp}, s);
   endtask
   task wait_done;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (done !== 1'b1 && n < 5000);
      check({31'h0, done}, 32'h1, "conv_done");
   endtask
   // no result may be stored over the span
   task quiet(input int cyc);
      int c;
      c = 0;
      repeat (cyc) begin
         @(posedge clk_sys);
         if (done === 1'b1) c++;
      end
      check(c, 0, "done pulses");
   endtask
   // cycles between two modulator ticks, after a settled first one
   task tick_gap(input int exp, input string s);
      int c;
      c = 0;
      do begin
         @(posedge clk_sys);
      end while (tick !== 1'b1);
      do begin
         @(posedge clk_sys);
         c++;
      end while (tick !== 1'b1);
      check(c, exp, s);
   endtask
   // coherent read under hold, keeping divider and buffer bits
   task snap(input logic [23:0] exp);
      cmd(3'h3, 8'h00, 8'h58);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, {8'h0, exp}, "result");
   endtask
   function automatic logic [31:0] m(input dsac_pkg::dsac_mode_e e);
      return {30'h0, e};
   endfunction
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      check(m(op_mode), m(dsac_pkg::DSAC_POWER_DOWN), "mode");
      dev_rd(8'h07, 8'h20, "conv_control");
      dev_rd(8'h08, 8'h00, "filter_control");
      dev_rd(8'h09, 8'h00, "clock_divider");
      cmd(3'h1, 8'h09, 8'hff);
      dev_rd(8'h09, 8'h1f, "clock_divider");
      cmd(3'h1, 8'h08, 8'hff);
      dev_rd(8'h08, 8'hfc, "filter_control");
      dev_rd(8'h0a, 8'h00, "unmapped");
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, err}, 32'h1, "pslverr");
      $display("registers test done");
      cmd(3'h1, 8'h08, 8'h58);
      sample_data <= 26'h0012345;
      cmd(3'h2, 8'h00, 8'h0f);
      check(m(op_mode), m(dsac_pkg::DSAC_NORMAL), "mode");
      check({31'h0, ref_ext}, 32'h1, "ref_ext_sel");
      check({30'h0, neg_on, pos_on}, 32'h3, "buffers");
      wait_done;
      wait_done;
      check(n, 3072, "conversion cycles");
      dev_rd(8'h08, 8'h5a, "done flag");
      snap(24'h012345);
      sample_data <= 26'h1000000;
      wait_done;
      snap(24'h7fffff);
      cmd(3'h1, 8'h08, 8'h5c);
      sample_data <= 26'h2000000;
      quiet(3500);
      dev_rd(8'h08, 8'h5c, "done flag held");
      snap(24'h7fffff);
      wait_done;
      snap(24'h800000);
      $display("conversion test done");
      // slow data rate settings, then a divided master clock
      cmd(3'h1, 8'h07, 8'h03);
      cmd(3'h1, 8'h08, 8'h1a);
      tick_gap(30, "tick gap n30");
      cmd(3'h1, 8'h09, 8'h00);
      tick_gap(60, "tick gap div2");
      $display("clock test done");
      cmd(3'h1, 8'h07, 8'h8f);
      check(m(op_mode), m(dsac_pkg::DSAC_FILT_RESET), "mode");
      check({31'h0, filt_rst}, 32'h1, "filter_reset");
      quiet(3500);
      cmd(3'h1, 8'h07, 8'h4f);
      check(m(op_mode), m(dsac_pkg::DSAC_SLEEP), "mode");
      check({29'h0, mod_on, filt_on, pos_on}, 32'h2, "sleep");
      cmd(3'h4, 8'h00, 8'h4f);
      check(m(op_mode), m(dsac_pkg::DSAC_POWER_DOWN), "mode");
      check({31'h0, filt_on}, 32'h0, "filter_on");
      dev_rd(8'h07, 8'h6f, "conv_control");
      $display("mode test done");
      end_sim;
   end
   // cut a hang short well past the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_mismatch++;
      end_sim;
   end
endmodule
`default_nettype wire

// ===== verilog/dsac_consts.svh
// Behaviour
// - filter reset bit holds filter, aborts result
// - no new conversion until reset bit clear
// - power-off bit downs everything, overrides others
// - sleep: modulator, sensor, buffers off, filter on
// - four modes decoded from three control bits
// - oversample code maps 16384..128, top bit 32768
// - reference pair: internal when zero, external one
// - modulator divider: code 000 /30, 010 /12
// - buffer bits: zero bypass, one enable buffer
// - hold bit freezes result, later results discarded
// - holding keeps converting, done flag unchanged
// - host holds results around three byte reads
// - hardware sets done flag, software clears it
// - data rate is modulator clock over 2*OSR
// - master divider 2*(code+1), code 11111 undivided
// - unimplemented divider and filter bits read zero
// - host powers converter off before idling
// - host uses 10 Hz and 25 Hz settings
// - host start: clear off/sleep, pulse reset bit
// - result 24-bit two's complement, saturating
`ifndef DSAC_CONSTS_SVH
`define DSAC_CONSTS_SVH
// device register offsets
`define DSAC_OFF_RES_LO 8'h04
`define DSAC_OFF_RES_MID 8'h05
`define DSAC_OFF_RES_HI 8'h06
`define DSAC_OFF_CONV 8'h07
`define DSAC_OFF_FILT 8'h08
`define DSAC_OFF_CKDIV 8'h09
// conversion_control fields
`define DSAC_CONV_RST_BIT 7
`define DSAC_CONV_SLP_BIT 6
`define DSAC_CONV_OFF_BIT 5
`define DSAC_CONV_OSR_LSB 1
`define DSAC_CONV_VREF_BIT 0
`define DSAC_CONV_RST_VAL 8'h20
// filter_buffer_control fields
`define DSAC_FILT_MDIV_LSB 5
`define DSAC_FILT_NBUF_BIT 4
`define DSAC_FILT_PBUF_BIT 3
`define DSAC_FILT_HOLD_BIT 2
`define DSAC_FILT_EOC_BIT 1
`define DSAC_FILT_RST_VAL 8'h00
`define DSAC_FILT_CTL_RST_VAL 6'h00
`define DSAC_EOC_RST_VAL 1'b0
// clock_divider_control
`define DSAC_CKDIV_RST_VAL 5'h00
`define DSAC_CKDIV_BYPASS 5'h1f
// modulator divider codes and last counts
`define DSAC_MDIV_12 3'h2
`define DSAC_N30_LAST 5'h1d
`define DSAC_N12_LAST 5'h0b
// twice the oversampling ratio, in modulator ticks
`define DSAC_CONV_LEN_TOP 17'h10000
`define DSAC_CONV_LEN_BASE 17'h00100
// saturation limits
`define DSAC_SAT_POS 24'h7fffff
`define DSAC_SAT_NEG 24'h800000
// host apb map
`define DSAC_APB_CMD 8'h00
`define DSAC_APB_STAT 8'h04
`define DSAC_APB_RESULT 8'h08
`define DSAC_CMD_WD_LSB 8
`define DSAC_CMD_OP_LSB 16
`define DSAC_STAT_RD_LSB 8
`endif

// ===== verilog/dsac_dev.sv
`include "dsac_consts.svh"
`default_nettype none
module dsac_dev (
   input wire logic clk_sys,
   input wire logic rst_b,
   dsac_if.dev bus,
   input wire logic signed [25:0] sample_data,
   output dsac_pkg::dsac_mode_e op_mode,
   output logic modulator_on,
   output logic filter_on,
   output logic filter_reset,
   output logic ref_ext_sel,
   output logic neg_ref_buffer_on,
   output logic pos_ref_buffer_on,
   output logic adck_tick,
   output logic conv_done
);
   // conversion_control fields
   logic filter_reset_ctl_reg; // filter reset bit
   logic sleep_select_reg; // sleep select bit
   logic converter_power_off_reg; // power-off bit
   logic [3:0] oversample_select_reg; // oversampling code
   logic reference_pair_select_reg; // reference pair select
   // filter_buffer_control fields
   logic [2:0] modulator_clock_divider_reg; // modulator divider code
   logic neg_ref_buffer_on_reg; // negative buffer enable
   logic pos_ref_buffer_on_reg; // positive buffer enable
   logic result_hold_on_reg; // result hold bit
   logic eoc_reg; // conversion done flag
   // clock_divider_control
   logic [4:0] master_clock_divider_reg;
   // result and counters
   logic [23:0] result_reg; // last stored result
   logic [5:0] mcnt_reg; // master divider count
   logic mclk_tick_reg; // master clock enable
   logic [4:0] acnt_reg; // modulator divider count
   logic [16:0] conv_cnt_reg; // modulator ticks in conversion
   // bus answer
   logic ack_reg;
   logic [7:0] rdata_reg;
   // outputs
   dsac_pkg::dsac_mode_e mode_reg;
   logic modulator_on_reg;
   logic filter_on_reg;
   logic filter_reset_reg;
   logic ref_ext_sel_reg;
   logic nbuf_out_reg;
   logic pbuf_out_reg;
   logic adck_tick_reg;
   logic conv_done_reg;

   // bus access decode: a request is taken once, on its first cycle
   wire take = bus.reg_req & ~ack_reg;
   wire wr = take & bus.reg_we;
   wire wr_conv = wr & (bus.reg_addr == `DSAC_OFF_CONV);
   wire wr_filt = wr & (bus.reg_addr == `DSAC_OFF_FILT);
   wire wr_ckdiv = wr & (bus.reg_addr == `DSAC_OFF_CKDIV);

   // mode decode, power-off dominates, then sleep, then reset
   wire dsac_pkg::dsac_mode_e mode_next =
      converter_power_off_reg ? dsac_pkg::DSAC_POWER_DOWN :
      sleep_select_reg ? dsac_pkg::DSAC_SLEEP :
      filter_reset_ctl_reg ? dsac_pkg::DSAC_FILT_RESET :
      dsac_pkg::DSAC_NORMAL;
   wire is_pd = (mode_next == dsac_pkg::DSAC_POWER_DOWN);
   wire is_norm = (mode_next == dsac_pkg::DSAC_NORMAL);
   // modulator runs in normal and in filter-reset mode only
   wire mod_run = is_norm | (mode_next == dsac_pkg::DSAC_FILT_RESET);

   // master divider: last count 2*code+1 gives divide by 2*(code+1)
   wire bypass = (master_clock_divider_reg == `DSAC_CKDIV_BYPASS);
   wire [5:0] mlast = {master_clock_divider_reg, 1'b1};
   wire mwrap = (mcnt_reg == mlast);
   wire mtick_next = ~is_pd & (bypass | mwrap);

   // modulator divider; reserved codes fall back to divide by 30
   wire [4:0] alast =
      (modulator_clock_divider_reg == `DSAC_MDIV_12) ?
      `DSAC_N12_LAST : `DSAC_N30_LAST;
   wire awrap = mclk_tick_reg & (acnt_reg == alast);
   wire atick_next = mod_run & awrap;

   // conversion length is 2*OSR modulator ticks
   wire [2:0] osr_shift = 3'h7 - oversample_select_reg[2:0];
   wire [16:0] conv_len = oversample_select_reg[3] ?
      `DSAC_CONV_LEN_TOP : (`DSAC_CONV_LEN_BASE << osr_shift);
   wire conv_last = (conv_cnt_reg == conv_len - 17'h1);
   // a conversion ends only in normal mode
   wire conv_end = is_norm & adck_tick_reg & conv_last;
   // the hold bit drops finished results on the floor
   wire store = conv_end & ~result_hold_on_reg;

   // saturation of the filter output to 24 bits
   wire ovr = (sample_data[25:23] != {3{sample_data[25]}});
   wire [23:0] sat_val = ~ovr ? sample_data[23:0] :
      (sample_data[25] ? `DSAC_SAT_NEG : `DSAC_SAT_POS);

   // done flag: hardware set wins over a software clear
   wire eoc_clr = wr_filt & ~bus.reg_wdata[`DSAC_FILT_EOC_BIT];
   wire eoc_next = store | (eoc_reg & ~eoc_clr);

   // read mux, unused bit positions read zero
   wire [7:0] conv_rd = {filter_reset_ctl_reg, sleep_select_reg,
      converter_power_off_reg, oversample_select_reg,
      reference_pair_select_reg};
   wire [7:0] filt_rd = {modulator_clock_divider_reg,
      neg_ref_buffer_on_reg, pos_ref_buffer_on_reg,
      result_hold_on_reg, eoc_reg, 1'b0};
   wire [7:0] ckdiv_rd = {3'h0, master_clock_divider_reg};
   wire [7:0] rd_mux =
      (bus.reg_addr == `DSAC_OFF_RES_LO) ? result_reg[7:0] :
      (bus.reg_addr == `DSAC_OFF_RES_MID) ? result_reg[15:8] :
      (bus.reg_addr == `DSAC_OFF_RES_HI) ? result_reg[23:16] :
      (bus.reg_addr == `DSAC_OFF_CONV) ? conv_rd :
      (bus.reg_addr == `DSAC_OFF_FILT) ? filt_rd :
      (bus.reg_addr == `DSAC_OFF_CKDIV) ? ckdiv_rd :
      8'h00; // unmapped offsets read zero

   // bus answer one cycle after the request is seen
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ack_reg <= take;
         if (take) begin
            rdata_reg <= rd_mux; // writes also return the old value
         end
      end
   end

   // conversion_control register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {filter_reset_ctl_reg, sleep_select_reg,
            converter_power_off_reg, oversample_select_reg,
            reference_pair_select_reg} <= `DSAC_CONV_RST_VAL;
      end else if (wr_conv) begin
         {filter_reset_ctl_reg, sleep_select_reg,
            converter_power_off_reg, oversample_select_reg,
            reference_pair_select_reg} <= bus.reg_wdata;
      end
   end

   // filter_buffer_control register, done flag kept apart
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {modulator_clock_divider_reg, neg_ref_buffer_on_reg,
            pos_ref_buffer_on_reg, result_hold_on_reg} <=
            `DSAC_FILT_CTL_RST_VAL;
      end else if (wr_filt) begin
         {modulator_clock_divider_reg, neg_ref_buffer_on_reg,
            pos_ref_buffer_on_reg, result_hold_on_reg} <=
            bus.reg_wdata[7:2];
      end
   end

   // done flag
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         eoc_reg <= `DSAC_EOC_RST_VAL;
      end else begin
         eoc_reg <= eoc_next;
      end
   end

   // clock_divider_control register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         master_clock_divider_reg <= `DSAC_CKDIV_RST_VAL;
      end else if (wr_ckdiv) begin
         master_clock_divider_reg <= bus.reg_wdata[4:0];
      end
   end

   // master clock enable; counter parked while powered down
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mcnt_reg <= 6'h00;
         mclk_tick_reg <= 1'b0;
      end else begin
         // a new divider code restarts the count cleanly
         if (is_pd | bypass | mwrap | wr_ckdiv) begin
            mcnt_reg <= 6'h00;
         end else begin
            mcnt_reg <= mcnt_reg + 6'h01;
         end
         mclk_tick_reg <= mtick_next;
      end
   end

   // modulator clock enable, stopped in sleep and power down
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         acnt_reg <= 5'h00;
         adck_tick_reg <= 1'b0;
      end else begin
         if (~mod_run | awrap) begin
            acnt_reg <= 5'h00;
         end else if (mclk_tick_reg) begin
            acnt_reg <= acnt_reg + 5'h01;
         end
         adck_tick_reg <= atick_next;
      end
   end

   // conversion counter; any mode but normal abandons the result
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         conv_cnt_reg <= 17'h00000;
      end else if (~is_norm | conv_end) begin
         conv_cnt_reg <= 17'h00000;
      end else if (adck_tick_reg) begin
         conv_cnt_reg <= conv_cnt_reg + 17'h00001;
      end
   end

   // result store; held or non-normal results never land here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         result_reg <= 24'h000000;
      end else if (store) begin
         result_reg <= sat_val;
      end
   end

   // analog control outputs, all registered
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= dsac_pkg::DSAC_POWER_DOWN;
         modulator_on_reg <= 1'b0;
         filter_on_reg <= 1'b0;
         filter_reset_reg <= 1'b0;
         ref_ext_sel_reg <= 1'b0;
         nbuf_out_reg <= 1'b0;
         pbuf_out_reg <= 1'b0;
         conv_done_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         modulator_on_reg <= mod_run;
         filter_on_reg <= ~is_pd;
         filter_reset_reg <= filter_reset_ctl_reg & ~is_pd;
         ref_ext_sel_reg <= reference_pair_select_reg;
         // buffers only live while the modulator runs
         nbuf_out_reg <= mod_run & neg_ref_buffer_on_reg;
         pbuf_out_reg <= mod_run & pos_ref_buffer_on_reg;
         conv_done_reg <= store;
      end
   end

   assign bus.reg_ack = ack_reg;
   assign bus.reg_rdata = rdata_reg;
   assign op_mode = mode_reg;
   assign modulator_on = modulator_on_reg;
   assign filter_on = filter_on_reg;
   assign filter_reset = filter_reset_reg;
   assign ref_ext_sel = ref_ext_sel_reg;
   assign neg_ref_buffer_on = nbuf_out_reg;
   assign pos_ref_buffer_on = pbuf_out_reg;
   assign adck_tick = adck_tick_reg;
   assign conv_done = conv_done_reg;
endmodule
`default_nettype wire

// ===== verilog/dsac_host.sv
`include "dsac_consts.svh"
`default_nettype none
module dsac_host (
   input wire logic clk_sys,
   input wire logic rst_b,
   dsac_if.host bus,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   dsac_pkg::dsac_hstate_e state_reg;
   dsac_pkg::dsac_op_e op_reg; // running command
   logic [7:0] addr_reg; // command offset
   logic [7:0] wd_reg; // command byte
   logic [2:0] step_reg; // step inside command
   logic [7:0] rd_reg; // last byte read
   logic [23:0] snap_reg; // coherent result
   logic req_reg;
   logic we_reg;
   logic [7:0] baddr_reg;
   logic [7:0] bdata_reg;
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   // step table: last flag, direction, offset, data
   logic s_last;
   logic s_we;
   logic [7:0] s_addr;
   logic [7:0] s_data;

   always_comb begin
      s_last = 1'b1;
      s_we = 1'b1;
      s_addr = `DSAC_OFF_CONV;
      s_data = wd_reg;
      unique case (op_reg)
         dsac_pkg::DSAC_OP_READ: begin
            s_we = 1'b0;
            s_addr = addr_reg;
         end
         dsac_pkg::DSAC_OP_WRITE: begin
            s_addr = addr_reg;
         end
         dsac_pkg::DSAC_OP_START: begin
            // power up, then pulse the filter reset bit
            s_last = (step_reg == 3'h2);
            s_data = {step_reg == 3'h1, 2'h0, wd_reg[4:0]};
         end
         dsac_pkg::DSAC_OP_SNAP: begin
            // hold, read low-mid-high, release; done bit written 1
            s_last = (step_reg == 3'h4);
            s_we = (step_reg == 3'h0) | (step_reg == 3'h4);
            s_addr = (step_reg == 3'h1) ? `DSAC_OFF_RES_LO :
               (step_reg == 3'h2) ? `DSAC_OFF_RES_MID :
               (step_reg == 3'h3) ? `DSAC_OFF_RES_HI : `DSAC_OFF_FILT;
            s_data = {wd_reg[7:3], step_reg == 3'h0, 2'h2};
         end
         default: begin
            // power the converter off before the system idles
            s_data = wd_reg | 8'h20;
         end
      endcase
   end

   // apb decode; one wait state, answer from flops
   wire acc = psel & penable;
   wire done = acc & pready_reg;
   wire busy = (state_reg != dsac_pkg::DSAC_H_IDLE);
   wire cmd_hit = (paddr == `DSAC_APB_CMD);
   wire mapped = cmd_hit | (paddr == `DSAC_APB_STAT) |
      (paddr == `DSAC_APB_RESULT);
   wire start = done & pwrite & cmd_hit & ~busy & mapped;
   wire [31:0] rd_mux =
      (paddr == `DSAC_APB_STAT) ? {16'h0000, rd_reg, 7'h00, busy} :
      (paddr == `DSAC_APB_RESULT) ? {8'h00, snap_reg} :
      (cmd_hit ? {13'h0000, op_reg, wd_reg, addr_reg} : 32'h00000000);
   wire got = (state_reg == dsac_pkg::DSAC_H_REQ) & bus.reg_ack;

   // apb answer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= acc & ~pready_reg;
         prdata_reg <= rd_mux;
         pslverr_reg <= acc & ~pready_reg & ~mapped;
      end
   end

   // command capture; a write while busy is dropped
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         op_reg <= dsac_pkg::DSAC_OP_READ;
         addr_reg <= 8'h00;
         wd_reg <= 8'h00;
      end else if (start) begin
         op_reg <= dsac_pkg::dsac_op_e'(pwdata[`DSAC_CMD_OP_LSB +: 3]);
         addr_reg <= pwdata[7:0];
         wd_reg <= pwdata[`DSAC_CMD_WD_LSB +: 8];
      end
   end

   // link sequencer: request held until ack, then one idle cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= dsac_pkg::DSAC_H_IDLE;
         step_reg <= 3'h0;
         req_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            dsac_pkg::DSAC_H_IDLE: begin
               step_reg <= 3'h0;
               if (start) begin
                  state_reg <= dsac_pkg::DSAC_H_GAP;
               end
            end
            dsac_pkg::DSAC_H_GAP: begin
               req_reg <= 1'b1;
               state_reg <= dsac_pkg::DSAC_H_REQ;
            end
            dsac_pkg::DSAC_H_REQ: begin
               if (bus.reg_ack) begin
                  req_reg <= 1'b0;
                  step_reg <= step_reg + 3'h1;
                  state_reg <= s_last ? dsac_pkg::DSAC_H_IDLE :
                     dsac_pkg::DSAC_H_GAP;
               end
            end
            default: begin
               state_reg <= dsac_pkg::DSAC_H_IDLE;
            end
         endcase
      end
   end

   // request fields, loaded as the request rises
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         we_reg <= 1'b0;
         baddr_reg <= 8'h00;
         bdata_reg <= 8'h00;
      end else if (state_reg == dsac_pkg::DSAC_H_GAP) begin
         we_reg <= s_we;
         baddr_reg <= s_addr;
         bdata_reg <= s_data;
      end
   end

   // read capture and coherent result assembly
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_reg <= 8'h00;
         snap_reg <= 24'h000000;
      end else if (got & ~we_reg) begin
         rd_reg <= bus.reg_rdata;
         if (op_reg == dsac_pkg::DSAC_OP_SNAP) begin
            snap_reg <= {bus.reg_rdata, snap_reg[23:8]};
         end
      end
   end

   assign bus.reg_req = req_reg;
   assign bus.reg_we = we_reg;
   assign bus.reg_addr = baddr_reg;
   assign bus.reg_wdata = bdata_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

// ===== verilog/dsac_if.sv
`default_nettype none
interface dsac_if;
   logic reg_req; // host request, held until ack
   logic reg_we; // write when high
   logic [7:0] reg_addr; // register offset
   logic [7:0] reg_wdata; // write byte
   logic [7:0] reg_rdata; // read byte, valid with ack
   logic reg_ack; // one-cycle answer
   modport dev (
      input reg_req,
      input reg_we,
      input reg_addr,
      input reg_wdata,
      output reg_rdata,
      output reg_ack
   );
   modport host (
      output reg_req,
      output reg_we,
      output reg_addr,
      output reg_wdata,
      input reg_rdata,
      input reg_ack
   );
endinterface
`default_nettype wire

// ===== verilog/dsac_pkg.sv
`default_nettype none
package dsac_pkg;
   // converter operating mode
   typedef enum logic [1:0] {
      DSAC_POWER_DOWN,
      DSAC_SLEEP,
      DSAC_NORMAL,
      DSAC_FILT_RESET
   } dsac_mode_e;
   // host command kinds
   typedef enum logic [2:0] {
      DSAC_OP_READ,
      DSAC_OP_WRITE,
      DSAC_OP_START,
      DSAC_OP_SNAP,
      DSAC_OP_PWROFF
   } dsac_op_e;
   // host link states
   typedef enum logic [1:0] {
      DSAC_H_IDLE,
      DSAC_H_REQ,
      DSAC_H_GAP
   } dsac_hstate_e;
endpackage
`default_nettype wire
